// ### src/sac_pkg.sv
// Overview of operation
// R01: gain upper byte at index 04, reset FC
// R02: gain lower nibble at index 07, bits 7-4
// R03: extra gain bit adds one sixty-fourth
// R04: five-bit selector routes pins, sensor, supply, ground
// R05: selector top three bits read zero
// R06: conversion clock is source over divider+1
// R07: repeat field sums 1, 4, 8, 16
// R08: burst series needs one trigger only
// R09: right justified sum, zero upper bits
// R10: left justified 12 bits, low nibble zero
// R11: software keeps right justify when repeating
// R12: enable bit off means converter shut down
// R13: busy high converting, completion on busy fall
// R14: busy write 1 starts only in mode 00
// R15: start mode picks soft, timers, pin edge
// R16: window flag sticky until software clears
// R17: burst without enable powers up per trigger
// R18: burst with enable stays powered always
// R19: tracking mode post, pre or dual
// R20: post-track 2..16 conversion clocks plus two
// R21: window compares result against both limits
// R22: greater-than high byte resets to FF
// R23: gain index via high byte, value via low
// R24: gain word over 4096 plus extra step
// R25: extra gain bit set after reset
// R26: inside strictly between, outside beyond limits
// R27: completion flag cleared only by software
package sac_pkg;
  localparam logic [7:0] ADDR_TRK    = 8'hBA;
  localparam logic [7:0] ADDR_MUX    = 8'hBB;
  localparam logic [7:0] ADDR_CFG    = 8'hBC;
  localparam logic [7:0] ADDR_RES_LO = 8'hBD;
  localparam logic [7:0] ADDR_RES_HI = 8'hBE;
  localparam logic [7:0] ADDR_GT_LO  = 8'hC2;
  localparam logic [7:0] ADDR_GT_HI  = 8'hC4;
  localparam logic [7:0] ADDR_LT_LO  = 8'hC5;
  localparam logic [7:0] ADDR_LT_HI  = 8'hC6;
  localparam logic [7:0] ADDR_CTL    = 8'hF8;
  localparam logic [7:0] GAIN_IDX_UPPER = 8'h04;
  localparam logic [7:0] GAIN_IDX_LOWER = 8'h07;
  localparam logic [7:0] GAIN_IDX_EXTRA = 8'h08;

  localparam logic [7:0]  TRK_RESET        = 8'hFF;
  localparam logic [4:0]  MUX_RESET        = 5'h1F;
  localparam logic [7:0]  CFG_RESET        = 8'hF8;
  localparam logic [7:0]  CTL_RESET        = 8'h00;
  localparam logic [15:0] GT_RESET         = 16'hFFFF;
  localparam logic [15:0] LT_RESET         = 16'h0000;
  localparam logic [7:0]  GAIN_UPPER_RESET = 8'hFC;
  localparam logic [3:0]  GAIN_LOWER_RESET = 4'h0;
  localparam logic        GAIN_EXTRA_RESET = 1'b1;

  localparam int CTL_EN = 7;
  localparam int CTL_BURST = 6;
  localparam int CTL_INT = 5;
  localparam int CTL_BUSY = 4;
  localparam int CTL_WINT = 3;
  localparam int CTL_LJST = 2;
  localparam int CTL_CM_MSB = 1;
  localparam int CFG_SC_MSB = 7;
  localparam int CFG_SC_LSB = 3;
  localparam int CFG_RPT_MSB = 2;
  localparam int CFG_RPT_LSB = 1;
  localparam int CFG_GAIN_PROG = 0;
  localparam int TRK_PWR_MSB = 7;
  localparam int TRK_PWR_LSB = 4;
  localparam int TRK_TM_MSB = 3;
  localparam int TRK_TM_LSB = 2;
  localparam int TRK_TK_MSB = 1;

  localparam logic [1:0] CM_SOFT = 2'b00;
  localparam logic [1:0] CM_TMR1 = 2'b01;
  localparam logic [1:0] CM_PIN  = 2'b10;
  localparam logic [1:0] CM_TMR2 = 2'b11;
  localparam logic [1:0] TM_POST = 2'b01;
  localparam logic [1:0] TM_PRE  = 2'b10;
  localparam logic [4:0] MUX_TEMP   = 5'h18;
  localparam logic [4:0] MUX_SUPPLY = 5'h19;

  localparam int CLK_PERIOD_NS = 25;
  localparam int PWRUP_STEP_NS = 200;
  localparam int PWRUP_STEP_CYC = (PWRUP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] POST_TRACK_SRC_CYC = 8'd2;
  localparam logic [7:0] POST_TRACK_BASE = 8'd2;

  typedef enum logic [2:0] {ST_IDLE, ST_POWERUP, ST_TRACK, ST_SRC_WAIT, ST_CONVERT} sac_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sac_sfr_req_t;

  typedef struct packed {
    logic       power_on;
    logic       track_en;
    logic       start;
    logic       sar_tick;
    logic       pin_sel;
    logic [3:0] pin;
    logic       temp_sel;
    logic       supply_sel;
    logic       gnd_sel;
  } sac_conv_ctl_t;

  typedef struct packed {
    logic [11:0] word;
    logic        extra;
  } sac_gain_t;
endpackage : sac_pkg

// ### src/sac_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl
  import sac_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          ce,
  input  wire sac_sfr_req_t  sfr,
  output logic [7:0]         sfr_rdata,
  input  wire logic          timer1_ovf,
  input  wire logic          timer2_ovf,
  input  wire logic          external_convert_start_pin,
  input  wire logic          burst_osc_tick,
  input  wire logic          core_done,
  input  wire logic [11:0]   core_data,
  output sac_conv_ctl_t      conv_ctl,
  output sac_gain_t          gain
);

  function automatic logic [4:0] rpt_target(input logic [1:0] r);
    case (r)
      2'b00:   return 5'd1;
      2'b01:   return 5'd4;
      2'b10:   return 5'd8;
      default: return 5'd16;
    endcase
  endfunction : rpt_target

  function automatic logic [15:0] justify(input logic [15:0] sum, input logic left);
    return left ? {sum[11:0], 4'h0} : sum;
  endfunction : justify

  function automatic logic win_match(input logic [15:0] r, input logic [15:0] gt,
                                     input logic [15:0] lt);
    if (lt > gt)
      return (r > gt) && (r < lt);
    else
      return (r > gt) || (r < lt);
  endfunction : win_match

  logic [7:0]  trk_reg,      trk_next;
  logic [4:0]  mux_reg,      mux_next;
  logic [7:0]  cfg_reg,      cfg_next;
  logic [7:0]  ctl_reg,      ctl_next;
  logic [15:0] result_reg,   result_next;
  logic [15:0] gt_reg,       gt_next;
  logic [15:0] lt_reg,       lt_next;
  logic [7:0]  gup_reg,      gup_next;
  logic [3:0]  glo_reg,      glo_next;
  logic        gext_reg,     gext_next;
  logic [7:0]  gidx_reg,     gidx_next;
  sac_state_t  state_reg,    state_next;
  logic [7:0]  cnt_reg,      cnt_next;
  logic [4:0]  conv_cnt_reg, conv_cnt_next;
  logic [15:0] acc_reg,      acc_next;
  logic [4:0]  div_cnt_reg,  div_cnt_next;
  logic        sar_tick_reg, sar_tick_next;
  logic        start_reg,    start_next;
  logic        ext_prev_reg, ext_prev_next;
  logic [7:0]  rdata_reg,    rdata_next;

  logic        busy;
  logic        en;
  logic        burst;
  logic        src_tick;
  logic        trig;
  logic        done_evt;
  logic        wr_ctl;
  logic [15:0] sum;
  logic [7:0]  pwr_cycles;
  logic [7:0]  post_cycles;
  logic [1:0]  tm;

  assign busy   = (state_reg != ST_IDLE);
  assign en     = ctl_reg[CTL_EN];
  assign burst  = ctl_reg[CTL_BURST];
  assign tm     = trk_reg[TRK_TM_MSB:TRK_TM_LSB];
  assign wr_ctl = sfr.wr && (sfr.addr == ADDR_CTL);
  // R06 source clock select
  assign src_tick = burst ? burst_osc_tick : 1'b1;
  // R17 power-up length
  assign pwr_cycles = 8'(({4'h0, trk_reg[TRK_PWR_MSB:TRK_PWR_LSB]} + 8'd1) * PWRUP_STEP_CYC);
  // R20 post-track length
  assign post_cycles = 8'(POST_TRACK_BASE << trk_reg[TRK_TK_MSB:0]);

  always_comb
  begin
    trig = 1'b0;
    // R15 trigger source
    unique case (ctl_reg[CTL_CM_MSB:0])
      // R14 soft start
      CM_SOFT: trig = wr_ctl && sfr.wdata[CTL_BUSY];
      CM_TMR1: trig = timer1_ovf;
      CM_PIN:  trig = external_convert_start_pin && !ext_prev_reg;
      CM_TMR2: trig = timer2_ovf;
    endcase
  end

  always_comb
  begin
    trk_next      = trk_reg;
    mux_next      = mux_reg;
    cfg_next      = cfg_reg;
    ctl_next      = ctl_reg;
    result_next   = result_reg;
    gt_next       = gt_reg;
    lt_next       = lt_reg;
    gup_next      = gup_reg;
    glo_next      = glo_reg;
    gext_next     = gext_reg;
    gidx_next     = gidx_reg;
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    conv_cnt_next = conv_cnt_reg;
    acc_next      = acc_reg;
    div_cnt_next  = div_cnt_reg;
    sar_tick_next = 1'b0;
    ext_prev_next = external_convert_start_pin;
    rdata_next    = rdata_reg;
    done_evt      = 1'b0;
    sum           = acc_reg + {4'h0, core_data};

    // R06 conversion clock divider
    if (src_tick)
    begin
      if (div_cnt_reg >= cfg_reg[CFG_SC_MSB:CFG_SC_LSB])
      begin
        div_cnt_next  = 5'd0;
        sar_tick_next = 1'b1;
      end
      else
        div_cnt_next = 5'(div_cnt_reg + 5'd1);
    end

    if (sfr.wr)
    begin
      unique case (sfr.addr)
        ADDR_TRK:    trk_next = sfr.wdata;
        // R05 top bits dropped
        ADDR_MUX:    mux_next = sfr.wdata[4:0];
        ADDR_CFG:    cfg_next = sfr.wdata;
        ADDR_RES_LO:
        begin
          // R23 indirect gain data
          if (cfg_reg[CFG_GAIN_PROG])
          begin
            // R01 upper gain byte
            if (gidx_reg == GAIN_IDX_UPPER)
              gup_next = sfr.wdata;
            // R02 lower gain nibble
            if (gidx_reg == GAIN_IDX_LOWER)
              glo_next = sfr.wdata[7:4];
            // R03 extra step bit
            if (gidx_reg == GAIN_IDX_EXTRA)
              gext_next = sfr.wdata[0];
          end
          else
            result_next[7:0] = sfr.wdata;
        end
        ADDR_RES_HI:
        begin
          // R23 indirect gain index
          if (cfg_reg[CFG_GAIN_PROG])
            gidx_next = sfr.wdata;
          else
            result_next[15:8] = sfr.wdata;
        end
        ADDR_GT_LO:  gt_next[7:0] = sfr.wdata;
        // R22 limit high byte
        ADDR_GT_HI:  gt_next[15:8] = sfr.wdata;
        ADDR_LT_LO:  lt_next[7:0] = sfr.wdata;
        ADDR_LT_HI:  lt_next[15:8] = sfr.wdata;
        // busy bit is never stored; it reflects the sequencer
        ADDR_CTL:    ctl_next = sfr.wdata & ~(8'h01 << CTL_BUSY);
        default:     ;
      endcase
    end

    unique case (state_reg)
      ST_IDLE:
      begin
        // R12 shutdown ignores triggers
        if (trig && (en || burst))
        begin
          // R17 power up first
          if (burst && !en && (conv_cnt_reg == 5'd0))
            state_next = ST_POWERUP;
          // R19 pre-tracking skips post-track
          else if (tm == TM_PRE)
            state_next = ST_CONVERT;
          else
            state_next = ST_TRACK;
        end
      end
      ST_POWERUP:
      begin
        cnt_next = 8'(cnt_reg + 8'd1);
        if (8'(cnt_reg + 8'd1) >= pwr_cycles)
          state_next = (tm == TM_PRE) ? ST_CONVERT : ST_TRACK;
      end
      ST_TRACK:
      begin
        // R20 conversion clock part
        if (sar_tick_reg)
        begin
          cnt_next = 8'(cnt_reg + 8'd1);
          if (8'(cnt_reg + 8'd1) >= post_cycles)
            state_next = ST_SRC_WAIT;
        end
      end
      ST_SRC_WAIT:
      begin
        // R20 source clock part
        if (src_tick)
        begin
          cnt_next = 8'(cnt_reg + 8'd1);
          if (8'(cnt_reg + 8'd1) >= POST_TRACK_SRC_CYC)
            state_next = ST_CONVERT;
        end
      end
      ST_CONVERT:
      begin
        if (core_done)
        begin
          // R07 repeat accumulation
          if (5'(conv_cnt_reg + 5'd1) >= rpt_target(cfg_reg[CFG_RPT_MSB:CFG_RPT_LSB]))
          begin
            // R09 R10 justification
            result_next   = justify(sum, ctl_reg[CTL_LJST]);
            done_evt      = 1'b1;
            acc_next      = 16'h0000;
            conv_cnt_next = 5'd0;
            state_next    = ST_IDLE;
          end
          else
          begin
            acc_next      = sum;
            conv_cnt_next = 5'(conv_cnt_reg + 5'd1);
            // R08 burst self-timed series
            if (burst)
              state_next = (tm == TM_PRE) ? ST_CONVERT : ST_TRACK;
            else
              state_next = ST_IDLE;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase

    if (state_next != state_reg)
      cnt_next = 8'd0;
    start_next = (state_next == ST_CONVERT) && ((state_reg != ST_CONVERT) || core_done);

    // R13 R27 completion flag, set wins
    if (done_evt)
      ctl_next[CTL_INT] = 1'b1;
    // R16 R21 R26 window flag, set wins
    if (done_evt && win_match(result_next, gt_reg, lt_reg))
      ctl_next[CTL_WINT] = 1'b1;

    if (sfr.rd)
    begin
      unique case (sfr.addr)
        ADDR_TRK:    rdata_next = trk_reg;
        // R05 top bits read zero
        ADDR_MUX:    rdata_next = {3'h0, mux_reg};
        ADDR_CFG:    rdata_next = cfg_reg;
        ADDR_RES_LO: rdata_next = result_reg[7:0];
        ADDR_RES_HI: rdata_next = result_reg[15:8];
        ADDR_GT_LO:  rdata_next = gt_reg[7:0];
        ADDR_GT_HI:  rdata_next = gt_reg[15:8];
        ADDR_LT_LO:  rdata_next = lt_reg[7:0];
        ADDR_LT_HI:  rdata_next = lt_reg[15:8];
        // R13 busy readback
        ADDR_CTL:    rdata_next = ctl_reg | ({7'h00, busy} << CTL_BUSY);
        default:     rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      trk_reg      <= TRK_RESET;
      mux_reg      <= MUX_RESET;
      cfg_reg      <= CFG_RESET;
      ctl_reg      <= CTL_RESET;
      result_reg   <= 16'h0000;
      gt_reg       <= GT_RESET;
      lt_reg       <= LT_RESET;
      gup_reg      <= GAIN_UPPER_RESET;
      glo_reg      <= GAIN_LOWER_RESET;
      // R25 extra bit reset
      gext_reg     <= GAIN_EXTRA_RESET;
      gidx_reg     <= 8'h00;
      state_reg    <= ST_IDLE;
      cnt_reg      <= 8'h00;
      conv_cnt_reg <= 5'h00;
      acc_reg      <= 16'h0000;
      div_cnt_reg  <= 5'h00;
      sar_tick_reg <= 1'b0;
      start_reg    <= 1'b0;
      ext_prev_reg <= 1'b0;
      rdata_reg    <= 8'h00;
    end
    else if (ce)
    begin
      trk_reg      <= trk_next;
      mux_reg      <= mux_next;
      cfg_reg      <= cfg_next;
      ctl_reg      <= ctl_next;
      result_reg   <= result_next;
      gt_reg       <= gt_next;
      lt_reg       <= lt_next;
      gup_reg      <= gup_next;
      glo_reg      <= glo_next;
      gext_reg     <= gext_next;
      gidx_reg     <= gidx_next;
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      conv_cnt_reg <= conv_cnt_next;
      acc_reg      <= acc_next;
      div_cnt_reg  <= div_cnt_next;
      sar_tick_reg <= sar_tick_next;
      start_reg    <= start_next;
      ext_prev_reg <= ext_prev_next;
      rdata_reg    <= rdata_next;
    end
  end

  assign sfr_rdata = rdata_reg;
  // R24 gain word to core
  assign gain.word  = {gup_reg, glo_reg};
  assign gain.extra = gext_reg;
  // R12 R17 R18 power control
  assign conv_ctl.power_on = en || (burst && busy);
  // reserved tracking code behaves as dual
  assign conv_ctl.track_en = conv_ctl.power_on &&
                             ((state_reg == ST_TRACK) || (state_reg == ST_SRC_WAIT) ||
                              ((state_reg == ST_IDLE) && (tm != TM_POST)));
  assign conv_ctl.start    = start_reg;
  assign conv_ctl.sar_tick = sar_tick_reg;
  // R04 input routing
  assign conv_ctl.pin_sel    = !mux_reg[4];
  assign conv_ctl.pin        = mux_reg[3:0];
  assign conv_ctl.temp_sel   = (mux_reg == MUX_TEMP);
  assign conv_ctl.supply_sel = (mux_reg == MUX_SUPPLY);
  // unlisted codes 10000-10111 also ground, safest default
  assign conv_ctl.gnd_sel    = mux_reg[4] && (mux_reg != MUX_TEMP) && (mux_reg != MUX_SUPPLY);

  logic [3:0] wd_hi;
  logic       wd_lo;
  logic       gwr;
  assign wd_hi = sfr.wdata[7:4];
  assign wd_lo = sfr.wdata[0];
  assign gwr   = ce && sfr.wr && (sfr.addr == ADDR_RES_LO) && cfg_reg[CFG_GAIN_PROG];

  AST_GAIN_UPPER_WRITE: assert property (@(posedge clk) disable iff (!rst_b) // R01
    (gwr && gidx_reg == GAIN_IDX_UPPER) |=> gain.word[11:4] == $past(sfr.wdata))
    else $error("gain upper byte not written");
  AST_GAIN_LOWER_WRITE: assert property (@(posedge clk) disable iff (!rst_b) // R02
    (gwr && gidx_reg == GAIN_IDX_LOWER) |=> gain.word[3:0] == $past(wd_hi))
    else $error("gain lower nibble not written");
  AST_GAIN_EXTRA_WRITE: assert property (@(posedge clk) disable iff (!rst_b) // R03
    (gwr && gidx_reg == GAIN_IDX_EXTRA) |=> gain.extra == $past(wd_lo))
    else $error("extra gain bit not written");
  AST_MUX_READ_TOP: assert property (@(posedge clk) disable iff (!rst_b) // R05
    (ce && sfr.rd && sfr.addr == ADDR_MUX) |=>
      (sfr_rdata[7:5] == 3'h0) && (sfr_rdata[4:0] == $past(mux_reg)))
    else $error("selector readback wrong");
  AST_BUSY_WRITE_START: assert property (@(posedge clk) disable iff (!rst_b) // R14
    (ce && !busy && wr_ctl && sfr.wdata[CTL_BUSY] && ctl_reg[CTL_EN] &&
     ctl_reg[CTL_CM_MSB:0] == CM_SOFT) |=> busy)
    else $error("soft start did not start");
  AST_COMPLETE_ON_DONE: assert property (@(posedge clk) disable iff (!rst_b) // R13
    (ce && done_evt) |=> (ctl_reg[CTL_INT] && !busy))
    else $error("completion flag not set at end");
  AST_COMPLETE_STICKY: assert property (@(posedge clk) disable iff (!rst_b) // R27
    (ctl_reg[CTL_INT] && !wr_ctl) |=> ctl_reg[CTL_INT])
    else $error("completion flag cleared by itself");
  AST_WINDOW_STICKY: assert property (@(posedge clk) disable iff (!rst_b) // R16
    (ctl_reg[CTL_WINT] && !wr_ctl) |=> ctl_reg[CTL_WINT])
    else $error("window flag cleared by itself");
  AST_LEFT_LOW_ZERO: assert property (@(posedge clk) disable iff (!rst_b) // R10
    (ce && done_evt && ctl_reg[CTL_LJST]) |=> result_reg[3:0] == 4'h0)
    else $error("left justified low nibble not zero");
  AST_POWER_FOLLOWS_EN: assert property (@(posedge clk) disable iff (!rst_b) // R18
    (!burst || en) |-> (conv_ctl.power_on == en))
    else $error("power does not follow enable");

endmodule : sac_ctrl
`default_nettype wire

// ### sim/sac_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module sac_core_model
  import sac_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire sac_conv_ctl_t ctl,
  input  wire logic [11:0]   value,
  input  wire logic [3:0]    lat,
  output logic               done,
  output logic [11:0]        data
);
  logic [3:0]  cnt_reg;
  logic [11:0] last_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_reg  <= 4'h0;
      done     <= 1'b0;
      last_reg <= 12'h000;
    end
    else
    begin
      done <= 1'b0;
      if (ctl.start && ctl.power_on)
        cnt_reg <= lat;
      else if (cnt_reg != 4'h0)
      begin
        cnt_reg <= cnt_reg - 4'h1;
        if (cnt_reg == 4'h1)
        begin
          done     <= 1'b1;
          last_reg <= value;
        end
      end
    end
  end

  // stale data inverted so a late sample never looks valid
  assign data = done ? last_reg : ~last_reg;
endmodule : sac_core_model
`default_nettype wire

// ### sim/sac_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control_window_tb
  import sac_pkg::*;
;
  logic           clk;
  logic           rst_b;
  logic           ce;
  sac_sfr_req_t   sfr;
  logic [7:0]     rdata;
  logic           t1;
  logic           t2;
  logic           pin;
  logic           btick;
  logic           done;
  logic [11:0]    cdata;
  logic [11:0]    dval;
  logic [3:0]     lat;
  sac_conv_ctl_t  cc;
  sac_gain_t      gn;
  logic           chk;
  logic           chk_d = 1'b0;
  logic [7:0]     exp_q [$];
  logic [7:0]     ctl_b;
  int             errors;
  int             tests_run;
  int             cyc;
  logic [7:0]     gtv [4] = '{8'h01, 8'h01, 8'h02, 8'h02};
  logic [7:0]     ltv [4] = '{8'h02, 8'h02, 8'h01, 8'h01};
  logic [11:0]    dv  [4] = '{12'h180, 12'h100, 12'h050, 12'h150};
  logic [7:0]     ev  [4] = '{8'hA9, 8'hA9, 8'hA9, 8'hA1};

  sac_ctrl u_dut (
    .clk                        (clk),
    .rst_b                      (rst_b),
    .ce                         (ce),
    .sfr                        (sfr),
    .sfr_rdata                  (rdata),
    .timer1_ovf                 (t1),
    .timer2_ovf                 (t2),
    .external_convert_start_pin (pin),
    .burst_osc_tick             (btick),
    .core_done                  (done),
    .core_data                  (cdata),
    .conv_ctl                   (cc),
    .gain                       (gn)
  );

  sac_core_model u_core (
    .clk   (clk),
    .rst_b (rst_b),
    .ctl   (cc),
    .value (dval),
    .lat   (lat),
    .done  (done),
    .data  (cdata)
  );

  always #12.5 clk = ~clk;

  // burst oscillator at half the system rate
  always @(posedge clk)
  begin
    #2;
    btick = ~btick;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      errors++;
      give_verdict();
    end
  end

  // read data lands one cycle after the read edge
  always @(posedge clk)
  begin
    if (chk_d)
      cmp(rdata, exp_q.pop_front());
    chk_d <= chk;
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic give_verdict();
    if (errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr.addr  = a;
    sfr.wdata = d;
    sfr.wr    = 1'b1;
    @(posedge clk);
    #2;
    sfr.wr = 1'b0;
    @(posedge clk);
    #2;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr.addr = a;
    sfr.rd   = 1'b1;
    chk      = 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    #2;
    sfr.rd = 1'b0;
    chk    = 1'b0;
    @(posedge clk);
    #2;
  endtask : rd

  task automatic wait_done(input int n);
    int k;
    repeat (n)
    begin
      k = 0;
      do
      begin
        @(posedge clk);
        k++;
      end while (done !== 1'b1 && k < 400);
      if (k >= 400)
        errors++;
    end
    repeat (3) @(posedge clk);
    #2;
  endtask : wait_done

  // mode 0 writes the busy bit, the others pulse their trigger input
  task automatic pulse(input int m);
    case (m)
      0: wr(ADDR_CTL, ctl_b | 8'h10);
      1: t1 = 1'b1;
      2: pin = 1'b1;
      default: t2 = 1'b1;
    endcase
    if (m != 0)
    begin
      @(posedge clk);
      #2;
      t1  = 1'b0;
      pin = 1'b0;
      t2  = 1'b0;
      @(posedge clk);
      #2;
    end
  endtask : pulse

  task automatic conv(input int m, input logic [11:0] d);
    dval = d;
    lat  = 4'($urandom_range(12, 1));
    pulse(m);
    wait_done(1);
  endtask : conv

  task automatic ticks(input int n, input int e);
    int c;
    c = 0;
    repeat (n)
    begin
      @(posedge clk);
      if (cc.sar_tick === 1'b1)
        c++;
    end
    #2;
    cmp(16'(c), 16'(e));
  endtask : ticks

  initial
  begin
    logic [7:0]  g;
    logic [11:0] d;
    logic [15:0] s;
    clk = 0; rst_b = 0; ce = 1; sfr = '0; chk = 0; t1 = 0; t2 = 0; pin = 0;
    btick = 0; dval = 12'h000; lat = 4'h3; ctl_b = 8'h00;
    errors = 0; tests_run = 0; cyc = 0;
    void'($urandom(32'h68658d43));
    repeat (20) @(posedge clk);
    #2;
    rst_b = 1;
    rd(ADDR_TRK, 8'hFF);
    rd(ADDR_MUX, 8'h1F);
    rd(ADDR_CFG, 8'hF8);
    rd(ADDR_CTL, 8'h00);
    rd(ADDR_RES_HI, 8'h00);
    rd(ADDR_GT_HI, 8'hFF);
    rd(8'h00, 8'h00);
    cmp(gn.word, 16'h0FC0);
    cmp(gn.extra, 16'h0001);
    wr(ADDR_MUX, 8'hE5);
    rd(ADDR_MUX, 8'h05);
    cmp({cc.pin_sel, cc.pin}, 16'h0015);
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_MUX, 8'h18 + 8'(i));
      cmp({cc.pin_sel, cc.temp_sel, cc.supply_sel, cc.gnd_sel}, 16'h4 >> i);
    end
    // clock enable low must drop the write
    ce = 1'b0;
    wr(ADDR_MUX, 8'h03);
    ce = 1'b1;
    rd(ADDR_MUX, 8'h1A);
    // index then value, reserved nibble zero
    g = 8'($urandom);
    wr(ADDR_CFG, 8'h09);
    wr(ADDR_RES_HI, GAIN_IDX_UPPER);
    wr(ADDR_RES_LO, g);
    wr(ADDR_RES_HI, GAIN_IDX_LOWER);
    wr(ADDR_RES_LO, 8'hA0);
    wr(ADDR_RES_HI, GAIN_IDX_EXTRA);
    wr(ADDR_RES_LO, 8'h00);
    wr(ADDR_CFG, 8'h18);
    cmp(gn.word, {4'h0, g, 4'hA});
    cmp(gn.extra, 16'h0000);
    ticks(40, 10);
    wr(ADDR_CTL, 8'h40);
    ticks(80, 10);
    wr(ADDR_TRK, 8'hF8);
    wr(ADDR_CFG, 8'h08);
    ctl_b = 8'h80;
    wr(ADDR_CTL, ctl_b);
    cmp(cc.power_on, 16'h0001);
    d = 12'($urandom);
    conv(0, d);
    rd(ADDR_CTL, 8'hA0);
    rd(ADDR_RES_HI, {4'h0, d[11:8]});
    rd(ADDR_RES_LO, d[7:0]);
    wr(ADDR_CTL, 8'hA0);
    rd(ADDR_CTL, 8'hA0);
    // left justify only with single conversions
    ctl_b = 8'h84;
    d = 12'($urandom);
    conv(0, d);
    rd(ADDR_RES_HI, d[11:4]);
    rd(ADDR_RES_LO, {d[3:0], 4'h0});
    for (int m = 1; m < 4; m++)
    begin
      ctl_b = 8'h80 | 8'(m);
      // mode lands first; busy write then uses it
      wr(ADDR_CTL, ctl_b);
      wr(ADDR_CTL, ctl_b | 8'h10);
      rd(ADDR_CTL, ctl_b);
      d = 12'($urandom);
      conv(m, d);
      rd(ADDR_RES_LO, d[7:0]);
      wr(ADDR_CTL, ctl_b);
    end
    ctl_b = 8'h80;
    wr(ADDR_CTL, ctl_b);
    wr(ADDR_CFG, 8'h0A);
    s = 16'h0000;
    for (int i = 0; i < 4; i++)
    begin
      d = 12'($urandom);
      s = s + 16'(d);
      conv(0, d);
      if (i < 3)
        rd(ADDR_CTL, 8'h80);
    end
    rd(ADDR_CTL, 8'hA0);
    rd(ADDR_RES_HI, s[15:8]);
    rd(ADDR_RES_LO, s[7:0]);
    wr(ADDR_CFG, 8'h0E);
    wr(ADDR_TRK, 8'h0C);
    ctl_b = 8'h41;
    wr(ADDR_CTL, ctl_b);
    cmp(cc.power_on, 16'h0000);
    d = 12'($urandom);
    s = {d, 4'h0};
    dval = d;
    lat = 4'h5;
    pulse(1);
    wait_done(1);
    cmp(cc.power_on, 16'h0001);
    wait_done(15);
    rd(ADDR_CTL, 8'h61);
    rd(ADDR_RES_HI, s[15:8]);
    rd(ADDR_RES_LO, s[7:0]);
    cmp(cc.power_on, 16'h0000);
    wr(ADDR_CTL, 8'hC1);
    cmp(cc.power_on, 16'h0001);
    cmp(cc.track_en, 16'h0001);
    wr(ADDR_TRK, 8'h04);
    cmp(cc.track_en, 16'h0000);
    wr(ADDR_CFG, 8'h08);
    wr(ADDR_GT_LO, 8'h00);
    wr(ADDR_LT_LO, 8'h00);
    ctl_b = 8'h81;
    wr(ADDR_CTL, ctl_b);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_GT_HI, gtv[i]);
      wr(ADDR_LT_HI, ltv[i]);
      conv(1, dv[i]);
      rd(ADDR_CTL, ev[i]);
      if (i > 0)
        wr(ADDR_CTL, ctl_b);
    end
    wr(ADDR_CTL, 8'h00);
    wr(ADDR_CTL, 8'h10);
    rd(ADDR_CTL, 8'h00);
    cmp(cc.power_on, 16'h0000);
    repeat (2) @(posedge clk);
    give_verdict();
  end
endmodule : sar_adc_control_window_tb
`default_nettype wire
